// ===== adc_gain_offset_calibration_bench.sv
// Self-checking bench for agc_top: register access and corrected samples.
// Assumes agc_checker.sv is compiled first; drives every input itself.
`timescale 1ns/1ps
`default_nettype none
`include "agc_map.svh"
module adc_gain_offset_calibration_bench;
  import agc_pkg::*;
  logic clock = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, rawValid = 0, resultValid;
  logic [15:0] wb_adr_i = 16'h0000, rawData = 16'h0000, resultData;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  agc_amp_type ampGain = AGC_AMP_X1;
  agc_chan_type chanSel = AGC_CH_VOLT;
  int nMismatch = 0, samplesChecked = 0, nSmp = 0;
  logic byp = 1'b0;
  logic [14:0] g2, g4, o4;
  logic [14:0] gt[7] = '{15'h0000, 15'h2000, 15'h4000, 15'h4001, 15'h7FFF, 15'h0001, 15'h3FFF};
  logic [14:0] ot[5] = '{15'h3FFF, 15'h0001, 15'h0000, 15'h7FFF, 15'h4000};
  // Free-running 100 MHz clock.
  always #5 clock = ~clock;
  agc_top u_dut (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .rawValid, .rawData, .ampGain, .chanSel, .resultValid, .resultData);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samplesChecked++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      nMismatch++;
    end
  endtask : chk
  task automatic endOfTest;
    if (nMismatch == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : endOfTest
  // Classic single cycle; the request stands until ack is sampled, whatever the latency.
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb
  // Offset first, then the gain multiply with floor, then the clamp to 16 bits.
  function automatic logic [15:0] model(input logic [15:0] r, input agc_amp_type a, input agc_chan_type c);
    longint v;
    if (byp || c != AGC_CH_VOLT || !(a inside {AGC_AMP_X2, AGC_AMP_X4})) return r;
    v = longint'(r) * 4 + ((a == AGC_AMP_X4) ? longint'($signed(o4)) : 0);
    v = (v * longint'((a == AGC_AMP_X2) ? g2 : g4)) >>> 16;
    if (v < 0) return 16'h0000;
    return (v > 65535) ? 16'hFFFF : v[15:0];
  endfunction : model
  task automatic smp(input logic [15:0] r, input agc_amp_type a, input agc_chan_type c);
    nSmp++;
    rawValid <= 1'b1;
    rawData <= r;
    ampGain <= a;
    chanSel <= c;
    @(posedge clock);
    rawValid <= 1'b0;
    #1;
    chk("resultData", {16'h0, model(r, a, c)}, {16'h0, resultData});
    @(posedge clock);
  endtask : smp
  // Reset, register defaults, then coefficient corners mixed with random ones.
  initial
  begin
    void'($urandom(94));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    wb(0, `AGC_ADDR_GAIN_X2, 0);
    chk("gainX2", 32'h4000, q);
    wb(0, `AGC_ADDR_GAIN_X4, 0);
    chk("gainX4", 32'h4000, q);
    wb(0, `AGC_ADDR_OFFSET_X4, 0);
    chk("offsetX4", 32'h0, q);
    wb(0, 16'h2000, 0);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 24; i++)
    begin
      g2 = (i < 7) ? gt[i] : 15'($urandom);
      g4 = (i < 7) ? gt[6 - i] : 15'($urandom);
      o4 = (i < 5) ? ot[i] : 15'($urandom);
      wb(1, `AGC_ADDR_GAIN_X2, {17'h1FFFF, g2});
      wb(1, `AGC_ADDR_GAIN_X4, {17'h1FFFF, g4});
      wb(1, `AGC_ADDR_OFFSET_X4, {17'h1FFFF, o4});
      wb(0, `AGC_ADDR_GAIN_X4, 0);
      chk("gainX4", {17'h0, g4}, q);
      for (int j = 0; j < 6; j++)
        smp((j == 0) ? 16'hFFFF : 16'($urandom), agc_amp_type'($urandom_range(4)), agc_chan_type'($urandom_range(2)));
      smp(16'($urandom), AGC_AMP_X4, AGC_CH_VOLT);
      smp(16'($urandom), AGC_AMP_X2, AGC_CH_VOLT);
    end
    // The status count must match the samples sent, modulo its 8-bit wrap.
    wb(0, `AGC_ADDR_STATUS, 0);
    chk("status", {24'h0, 8'(nSmp)}, q);
    // Bypass passes raw results even where correction would apply.
    wb(1, `AGC_ADDR_CONTROL, 32'h1);
    byp = 1'b1;
    wb(0, `AGC_ADDR_CONTROL, 0);
    chk("control", 32'h1, q);
    smp(16'($urandom), AGC_AMP_X4, AGC_CH_VOLT);
    smp(16'($urandom), AGC_AMP_X2, AGC_CH_VOLT);
    // A second reset in mid-run must bring gainX2, offsetX4, control and status back to their defaults.
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    byp = 1'b0;
    @(posedge clock);
    wb(0, `AGC_ADDR_GAIN_X2, 0);
    chk("gainX2", 32'h4000, q);
    wb(0, `AGC_ADDR_OFFSET_X4, 0);
    chk("offsetX4", 32'h0, q);
    wb(0, `AGC_ADDR_CONTROL, 0);
    chk("control", 32'h0, q);
    wb(0, `AGC_ADDR_STATUS, 0);
    chk("status", 32'h0, q);
    endOfTest;
  end
  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    #100000;
    nMismatch++;
    endOfTest;
  end
endmodule : adc_gain_offset_calibration_bench
bind agc_top agc_checker #(.DATA_W(DATA_W)) u_chk (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rawValid,
  .rawData, .ampGain, .chanSel, .resultValid, .resultData);
`default_nettype wire

// ===== agc_checker.sv
// Timing checks on the corrector's bus and sample ports.
// Assumes it is bound to agc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module agc_checker
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
)(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              rawValid,
  input wire logic [DATA_W-1:0] rawData,
  input wire agc_amp_type       ampGain,
  input wire agc_chan_type      chanSel,
  input wire logic              resultValid,
  input wire logic [DATA_W-1:0] resultData
);
  // One clock domain, so a single default clocking and disable serve every check.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  bus_ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  valid_next_a: assert property (rawValid |=> resultValid) else $error("no result");
  valid_cause_a: assert property (resultValid |-> $past(rawValid)) else $error("stray result");
  result_hold_a: assert property (!rawValid |=> $stable(resultData)) else $error("result moved");
  other_chan_a: assert property (rawValid && chanSel != AGC_CH_VOLT |=> resultData == $past(rawData))
    else $error("channel corrected");
  amp_x1_pass_a: assert property (rawValid && ampGain == AGC_AMP_X1 |=> resultData == $past(rawData))
    else $error("x1 corrected");
endmodule : agc_checker
`default_nettype wire

// ===== agc_corrector.sv
// Arithmetic core: offset, gain multiply, saturation, registered output.
// Assumes coefficients are stable while a sample is in flight.
`timescale 1ns/1ps
`default_nettype none
`include "agc_map.svh"
module agc_corrector
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
)(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   inValid,
  input  wire logic [DATA_W-1:0]      inData,
  input  wire logic [`AGC_COEF_W-1:0] gainCode,
  input  wire logic [`AGC_COEF_W-1:0] offsetCode,
  input  wire logic                   applyCorr,
  output logic                        outValid,
  output logic [DATA_W-1:0]           outData
);
  localparam int SUM_W  = DATA_W + `AGC_OFFSET_FRAC + 2;
  localparam int PROD_W = SUM_W + `AGC_COEF_W + 1;
  localparam logic [DATA_W-1:0] MAX_OUT = {DATA_W{1'b1}};

  logic signed [SUM_W-1:0]  sumQ;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] scaled;
  logic [DATA_W-1:0]        next_outData;

  // Result word is widened by two fractional bits so one offset step is a quarter LSB.
  always_comb
  begin
    sumQ = $signed({2'b00, inData, 2'b00}) + SUM_W'($signed(offsetCode)); // see [RL10] see [RL11] see [RL13]
    prod = PROD_W'(sumQ) * $signed({1'b0, gainCode}); // see [RL8] see [RL5] see [RL7]
    scaled = prod >>> (`AGC_GAIN_FRAC + `AGC_OFFSET_FRAC); // see [RL14]
    if (!applyCorr)
      next_outData = inData; // Unity and zero offset pass through: see [RL6] see [RL12]
    else if (gainCode == '0)
      next_outData = '0; // see [RL4]
    else if (scaled < 0)
      next_outData = '0; // see [RL14]
    else if (scaled > $signed({{(PROD_W-DATA_W){1'b0}}, MAX_OUT}))
      next_outData = MAX_OUT; // see [RL14]
    else
      next_outData = scaled[DATA_W-1:0];
  end

  // One register stage; arithmetic truncates toward minus infinity.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      outValid <= 1'b0;
      outData  <= '0;
    end
    else
    begin
      outValid <= inValid;
      if (inValid)
        outData <= next_outData;
    end
  end
endmodule : agc_corrector
`default_nettype wire

// ===== agc_map.svh
// Register map, field layout and reset values of the gain/offset corrector.
// Assumes a Wishbone slave with 32-bit data and byte addresses.
// What this block does
// [RL1] Amp gain 2 uses gain-2 coefficient.
// [RL2] Amp gain 4 uses gain-4 coefficient.
// [RL3] Gain field bits 14:0, fraction 13:0.
// [RL4] Zero gain code yields zero result.
// [RL5] Code 0x2000 halves the result.
// [RL6] Code 0x4000 is unity; reset value.
// [RL7] Codes above unity raise the result.
// [RL8] Multiplier equals code over 2^14.
// [RL9] Amp gain 4 applies gain-4 offset.
// [RL10] Positive offset adds quarter-LSB steps.
// [RL11] Top-bit-set offset codes subtract.
// [RL12] Zero offset no change; resets zero.
// [RL13] One offset step is quarter LSB.
// [RL14] Offset then gain, then saturate.
`ifndef AGC_MAP_SVH
`define AGC_MAP_SVH
`define AGC_ADDR_GAIN_X2    16'h2274
`define AGC_ADDR_GAIN_X4    16'h2278
`define AGC_ADDR_OFFSET_X4  16'h22D4
`define AGC_ADDR_CONTROL    16'h22E0
`define AGC_ADDR_STATUS     16'h22E4
`define AGC_COEF_MSB        14
`define AGC_COEF_W          15
`define AGC_GAIN_FRAC       14
`define AGC_OFFSET_FRAC     2
`define AGC_GAIN_RESET      15'h4000
`define AGC_OFFSET_RESET    15'h0000
`define AGC_CTRL_BYPASS_BIT 0
`endif

// ===== agc_pkg.sv
// Types shared by the gain/offset corrector files.
// Assumes agc_map.svh for numeric constants.
package agc_pkg;
  // Amplifier gain settings reported by the converter front end.
  typedef enum logic [2:0] {AGC_AMP_X1, AGC_AMP_X1P5, AGC_AMP_X2, AGC_AMP_X4, AGC_AMP_X9} agc_amp_type;
  // Channel classes; only auxiliary voltage channels are corrected.
  typedef enum logic [1:0] {AGC_CH_VOLT, AGC_CH_TIA, AGC_CH_TEMP} agc_chan_type;
endpackage : agc_pkg

// ===== agc_top.sv
// Top of the gain/offset corrector: Wishbone registers and selection of coefficients.
// Assumes raw results arrive on this clock with the amplifier and channel tags.
`timescale 1ns/1ps
`default_nettype none
`include "agc_map.svh"
module agc_top
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
)(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [15:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               rawValid,
  input  wire logic [DATA_W-1:0]  rawData,
  input  wire agc_amp_type        ampGain,
  input  wire agc_chan_type       chanSel,
  output logic                    resultValid,
  output logic [DATA_W-1:0]       resultData
);
  logic [`AGC_COEF_W-1:0] gainCoefAmpX2;
  logic [`AGC_COEF_W-1:0] gainCoefAmpX4;
  logic [`AGC_COEF_W-1:0] offsetCoefAmpX4;
  logic                   bypass;
  logic [`AGC_COEF_W-1:0] selGain;
  logic [`AGC_COEF_W-1:0] selOffset;
  logic                   applyCorr;
  logic [7:0]             sampleCount;
  logic                   busReq;

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Merges byte lanes of a write into a 15-bit coefficient field.
  function automatic logic [`AGC_COEF_W-1:0] merge(input logic [`AGC_COEF_W-1:0] cur,
                                                   input logic [31:0] d, input logic [3:0] s);
    logic [`AGC_COEF_W-1:0] r;
    r = cur;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[14:8] = d[14:8];
    return r;
  endfunction : merge

  // Coefficient registers; only bits 14:0 are stored, the rest read zero.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      gainCoefAmpX2   <= `AGC_GAIN_RESET; // see [RL6]
      gainCoefAmpX4   <= `AGC_GAIN_RESET; // see [RL6]
      offsetCoefAmpX4 <= `AGC_OFFSET_RESET; // see [RL12]
      bypass          <= 1'b0;
    end
    else if (busReq && wb_we_i)
    begin
      unique case (wb_adr_i)
        `AGC_ADDR_GAIN_X2:   gainCoefAmpX2 <= merge(gainCoefAmpX2, wb_dat_i, wb_sel_i); // see [RL3]
        `AGC_ADDR_GAIN_X4:   gainCoefAmpX4 <= merge(gainCoefAmpX4, wb_dat_i, wb_sel_i); // see [RL3]
        `AGC_ADDR_OFFSET_X4: offsetCoefAmpX4 <= merge(offsetCoefAmpX4, wb_dat_i, wb_sel_i);
        `AGC_ADDR_CONTROL:   if (wb_sel_i[0]) bypass <= wb_dat_i[`AGC_CTRL_BYPASS_BIT];
        default: ;
      endcase
    end
  end

  // Ack one cycle after the request, read data registered; unmapped reads give zero.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i)
      begin
        unique case (wb_adr_i)
          `AGC_ADDR_GAIN_X2:   wb_dat_o <= {17'h0, gainCoefAmpX2};
          `AGC_ADDR_GAIN_X4:   wb_dat_o <= {17'h0, gainCoefAmpX4};
          `AGC_ADDR_OFFSET_X4: wb_dat_o <= {17'h0, offsetCoefAmpX4};
          `AGC_ADDR_CONTROL:   wb_dat_o <= {31'h0, bypass};
          `AGC_ADDR_STATUS:    wb_dat_o <= {24'h0, sampleCount};
          default:             wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Counts every result sample, corrected or passed through, so software can see the datapath moving; wraps.
  always_ff @(posedge clock)
  begin
    if (rst)
      sampleCount <= 8'h00;
    else if (resultValid)
      sampleCount <= sampleCount + 8'h01;
  end

  // Coefficient choice: TIA and temperature channels and other gains pass uncorrected,
  // since their coefficients live elsewhere.
  always_comb
  begin
    selGain   = `AGC_GAIN_RESET;
    selOffset = `AGC_OFFSET_RESET;
    applyCorr = 1'b0;
    if (!bypass && chanSel == AGC_CH_VOLT)
    begin
      if (ampGain == AGC_AMP_X2)
      begin
        selGain   = gainCoefAmpX2; // see [RL1] see [RL14]
        applyCorr = 1'b1;
      end
      else if (ampGain == AGC_AMP_X4)
      begin
        selGain   = gainCoefAmpX4; // see [RL2] see [RL14]
        applyCorr = 1'b1;
      end
    end
    if (ampGain == AGC_AMP_X4 && applyCorr)
      selOffset = offsetCoefAmpX4; // see [RL9]
  end

  // Datapath with a single register stage.
  agc_corrector #(
    .DATA_W (DATA_W)
  ) u_corrector (
    .clock      (clock),
    .rst        (rst),
    .inValid    (rawValid),
    .inData     (rawData),
    .gainCode   (selGain),
    .offsetCode (selOffset),
    .applyCorr  (applyCorr),
    .outValid   (resultValid),
    .outData    (resultData)
  );
endmodule : agc_top
`default_nettype wire
